// ### src/dcc_top.sv
// Channel 0 control, software trigger and data holding registers of the converter
//
// Overview of operation
// - Width codes 8..A give 9..11, above give 12
// - Width n masks noise, triangle peaks at 2^n-1
// - Mode 00 none, 01 noise, 1x triangle
// - Source codes pick timers, line 9, software
// - Source ignored unless trigger enable set
// - Bit 2 turns triggered operation on or off
// - Bit 1 buffer off, bit 0 channel on
// - Software trigger bits self clear one cycle after the write
// - Offset 08 loads right-aligned twelve bits
// - Offset 0C loads left-aligned bits 15:4
// - Offset 10 loads eight upper bits
// - Trigger and data registers reset to zero
//
// Design decision made here: the address-and-strobe port.
`include "dcc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dcc_top #(
  parameter int DATA_W = 12
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [`DCC_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Trigger sources, one-cycle pulses
  input wire dcc_pkg::dcc_trig_s TRIG_IN,
  // Converter core side
  output dcc_pkg::dcc_core_s CORE,
  output logic SOFT_TRIG_CH1
);
  import dcc_pkg::*;

  initial begin
    if (DATA_W != 12) begin
      $error("dcc_top serves a 12-bit converter only");
    end
  end

  dcc_ctrl_s ctrl;
  logic [1:0] soft_trig;
  logic [11:0] held_value_ch0;
  logic [11:0] out_value;
  logic [11:0] lfsr;
  logic [11:0] tri_cnt;
  logic tri_down;
  logic trig_hit;
  logic trig_sel;
  logic [3:0] wave_n;
  logic [11:0] wave_mask;
  dcc_wave_e wave;
  logic [11:0] next_out;
  logic [11:0] lfsr_fb;

  wire wr_ctrl = WR && (ADDR == `DCC_OFF_CTRL);
  wire wr_swt = WR && (ADDR == `DCC_OFF_SWT);
  wire wr_r12 = WR && (ADDR == `DCC_OFF_R12);
  wire wr_l12 = WR && (ADDR == `DCC_OFF_L12);
  wire wr_r8 = WR && (ADDR == `DCC_OFF_R8);

  // Control word; only the channel 0 half is kept, the rest reads zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      ctrl.wave_width_ch0 <= WDATA[`DCC_F_WID_HI:`DCC_F_WID_LO];
      ctrl.wave_shape_ch0 <= WDATA[`DCC_F_MODE_HI:`DCC_F_MODE_LO];
      ctrl.trig_source_ch0 <= WDATA[`DCC_F_TSEL_HI:`DCC_F_TSEL_LO];
      ctrl.trig_on_ch0 <= WDATA[`DCC_F_TEN];
      ctrl.buffer_off_ch0 <= WDATA[`DCC_F_BOFF];
      ctrl.channel_on_ch0 <= WDATA[`DCC_F_EN];
    end
  end

  // Software trigger bits: held for one cycle then cleared by hardware
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      soft_trig <= 2'h0;
    end else if (wr_swt) begin
      soft_trig <= WDATA[`DCC_SWT1:`DCC_SWT0];
    end else begin
      soft_trig <= 2'h0;
    end
  end
  assign SOFT_TRIG_CH1 = soft_trig[1];

  // One holding value behind all three alignment views
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      held_value_ch0 <= `DCC_RST_VAL;
    end else if (wr_r12) begin
      held_value_ch0 <= WDATA[`DCC_R12_HI:`DCC_R12_LO];
    end else if (wr_l12) begin
      held_value_ch0 <= WDATA[`DCC_L12_HI:`DCC_L12_LO];
    end else if (wr_r8) begin
      held_value_ch0 <= {WDATA[`DCC_R8_HI:`DCC_R8_LO], 4'h0};
    end
  end

  // Trigger selection, only meaningful with triggering on
  always_comb begin
    case (ctrl.trig_source_ch0)
      3'h0: trig_sel = TRIG_IN.timer5;
      3'h1: trig_sel = TRIG_IN.timer2;
      3'h2: trig_sel = TRIG_IN.timer6;
      3'h3: trig_sel = TRIG_IN.timer4;
      3'h4: trig_sel = TRIG_IN.timer1;
      3'h5: trig_sel = TRIG_IN.timer3;
      `DCC_TSEL_EXT: trig_sel = TRIG_IN.ext_line9;
      `DCC_TSEL_SW: trig_sel = soft_trig[0];
      default: trig_sel = 1'b0;
    endcase
  end
  assign trig_hit = ctrl.trig_on_ch0 && trig_sel;

  // Width decode: codes beyond the largest saturate at 12
  always_comb begin
    if (ctrl.wave_width_ch0 >= `DCC_WID_MAX_CODE) begin
      wave_n = `DCC_WID_MAX;
    end else begin
      wave_n = ctrl.wave_width_ch0 + `DCC_WID_ONE;
    end
    wave_mask = 12'((13'h2 << (wave_n - `DCC_WID_ONE)) - 13'h1);
  end

  // Wave shape applies only in triggered operation
  always_comb begin
    if (!ctrl.trig_on_ch0 || ctrl.wave_shape_ch0 == 2'h0) begin
      wave = DCC_WAVE_NONE;
    end else if (ctrl.wave_shape_ch0 == 2'h1) begin
      wave = DCC_WAVE_LFSR;
    end else begin
      wave = DCC_WAVE_TRI;
    end
  end

  // Sum saturates at full scale instead of wrapping back to a low code
  always_comb begin
    logic [12:0] sum;
    sum = 13'h0;
    case (wave)
      DCC_WAVE_LFSR: sum = {1'b0, held_value_ch0} + {1'b0, lfsr & wave_mask};
      DCC_WAVE_TRI: sum = {1'b0, held_value_ch0} + {1'b0, tri_cnt};
      default: sum = {1'b0, held_value_ch0};
    endcase
    next_out = sum[12] ? 12'hFFF : sum[11:0];
  end

  // Noise register steps once per trigger
  assign lfsr_fb = {lfsr[10:0], ^(lfsr & `DCC_LFSR_TAPS)};
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lfsr <= `DCC_LFSR_SEED;
    end else if (trig_hit && wave == DCC_WAVE_LFSR) begin
      lfsr <= lfsr_fb;
    end
  end

  // Triangle counter bounces between zero and the amplitude
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tri_cnt <= 12'h000;
      tri_down <= 1'b0;
    end else if (wave != DCC_WAVE_TRI) begin
      tri_cnt <= 12'h000;
      tri_down <= 1'b0;
    end else if (trig_hit) begin
      if (!tri_down && tri_cnt >= wave_mask) begin
        tri_down <= 1'b1;
        tri_cnt <= tri_cnt - 12'h001;
      end else if (tri_down && tri_cnt == 12'h000) begin
        tri_down <= 1'b0;
        tri_cnt <= 12'h001;
      end else if (tri_down) begin
        tri_cnt <= tri_cnt - 12'h001;
      end else begin
        tri_cnt <= tri_cnt + 12'h001;
      end
    end
  end

  // Output word: direct transfer or on the selected trigger
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_value <= `DCC_RST_VAL;
    end else if (!ctrl.trig_on_ch0 || trig_hit) begin
      out_value <= next_out;
    end
  end
  assign CORE.data = out_value;
  assign CORE.channel_on = ctrl.channel_on_ch0;
  assign CORE.buffer_off = ctrl.buffer_off_ch0;

  // Read port: data one cycle after strobe, unmapped reads zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= `DCC_RST_WORD;
    end else if (RD) begin
      case (ADDR)
        `DCC_OFF_CTRL: RDATA <= {20'h0, ctrl};
        `DCC_OFF_SWT: RDATA <= {30'h0, soft_trig};
        `DCC_OFF_R12: RDATA <= {20'h0, held_value_ch0};
        `DCC_OFF_L12: RDATA <= {16'h0, held_value_ch0, 4'h0};
        `DCC_OFF_R8: RDATA <= {24'h0, held_value_ch0[11:4]};
        `DCC_OFF_STAT: RDATA <= {20'h0, out_value};
        default: RDATA <= `DCC_RST_WORD;
      endcase
    end else begin
      RDATA <= `DCC_RST_WORD;
    end
  end

  // Checks
  sequence s_swt_write;
    wr_swt && WDATA[0];
  endsequence

  property p_swt_clear;
    @(posedge CLK) disable iff (!RESETN)
      s_swt_write ##1 !wr_swt |=> !soft_trig[0];
  endproperty
  a_swt_clear: assert property (p_swt_clear) else $error("soft trigger not cleared");

  property p_swt_set;
    @(posedge CLK) disable iff (!RESETN) s_swt_write |=> soft_trig[0];
  endproperty
  a_swt_set: assert property (p_swt_set) else $error("soft trigger not set");

  property p_r12;
    @(posedge CLK) disable iff (!RESETN) wr_r12 |=> held_value_ch0 == $past(WDATA[11:0]);
  endproperty
  a_r12: assert property (p_r12) else $error("right12 load wrong");

  property p_l12;
    @(posedge CLK) disable iff (!RESETN) wr_l12 |=> held_value_ch0 == $past(WDATA[15:4]);
  endproperty
  a_l12: assert property (p_l12) else $error("left12 load wrong");

  property p_r8;
    @(posedge CLK) disable iff (!RESETN)
      wr_r8 |=> held_value_ch0 == {$past(WDATA[7:0]), 4'h0};
  endproperty
  a_r8: assert property (p_r8) else $error("right8 load wrong");

  property p_width;
    @(posedge CLK) disable iff (!RESETN)
      ctrl.wave_width_ch0 >= 4'hB |-> wave_mask == 12'hFFF;
  endproperty
  a_width: assert property (p_width) else $error("width not saturated");

  property p_no_trig;
    @(posedge CLK) disable iff (!RESETN)
      !ctrl.trig_on_ch0 && wr_r12 ##1 !ctrl.trig_on_ch0 |=> out_value == $past(held_value_ch0);
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("direct transfer missing");

  property p_hold;
    @(posedge CLK) disable iff (!RESETN)
      ctrl.trig_on_ch0 && !trig_hit |=> $stable(out_value);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without trigger");

  property p_ctrl;
    @(posedge CLK) disable iff (!RESETN)
      wr_ctrl |=> ctrl.trig_on_ch0 == $past(WDATA[2]) && ctrl.channel_on_ch0 == $past(WDATA[0]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control bits wrong");

  // Triangle selected by either mode code with the upper bit set
  property p_mode_tri;
    @(posedge CLK) disable iff (!RESETN)
      ctrl.trig_on_ch0 && ctrl.wave_shape_ch0[1] |-> wave == DCC_WAVE_TRI;
  endproperty
  a_mode_tri: assert property (p_mode_tri) else $error("triangle mode not selected");

  // A source pulse counts for nothing while triggering is off
  property p_trig_gate;
    @(posedge CLK) disable iff (!RESETN) !ctrl.trig_on_ch0 |-> !trig_hit;
  endproperty
  a_trig_gate: assert property (p_trig_gate) else $error("trigger seen while disabled");

  // Software trigger event with the software source selected
  sequence s_soft_fire;
    ctrl.trig_on_ch0 && ctrl.trig_source_ch0 == `DCC_TSEL_SW && soft_trig[0];
  endsequence

  property p_soft_route;
    @(posedge CLK) disable iff (!RESETN) s_soft_fire |-> trig_hit;
  endproperty
  a_soft_route: assert property (p_soft_route) else $error("soft trigger not routed");

  // With no wave the trigger moves the held value straight to the core
  property p_soft_out;
    @(posedge CLK) disable iff (!RESETN)
      s_soft_fire ##0 wave == DCC_WAVE_NONE |=> out_value == $past(held_value_ch0);
  endproperty
  a_soft_out: assert property (p_soft_out) else $error("triggered transfer missing");

  // Channel 1 software trigger request
  sequence s_swt1_write;
    wr_swt && WDATA[1];
  endsequence

  property p_swt1_set;
    @(posedge CLK) disable iff (!RESETN) s_swt1_write |=> SOFT_TRIG_CH1;
  endproperty
  a_swt1_set: assert property (p_swt1_set) else $error("channel 1 trigger not set");

  // Eight-bit view leaves the low nibble of the shared value clear
  property p_r8_low;
    @(posedge CLK) disable iff (!RESETN) wr_r8 |=> held_value_ch0[3:0] == 4'h0;
  endproperty
  a_r8_low: assert property (p_r8_low) else $error("right8 low nibble not cleared");

  // Read data stand only in the cycle after the strobe
  property p_read_gap;
    @(posedge CLK) disable iff (!RESETN) !RD |=> RDATA == `DCC_RST_WORD;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("read data outside read cycle");

  // Status word mirrors the converter output
  property p_stat;
    @(posedge CLK) disable iff (!RESETN)
      RD && ADDR == `DCC_OFF_STAT |=> RDATA == {20'h0, $past(out_value)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
endmodule : dcc_top

`default_nettype wire

// ### src/dcc_consts.svh
// Register offsets, field positions, reset values and encodings for the converter front end
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
`define DCC_ADDR_W 8
`define DCC_OFF_CTRL 8'h00
`define DCC_OFF_SWT 8'h04
`define DCC_OFF_R12 8'h08
`define DCC_OFF_L12 8'h0C
`define DCC_OFF_R8 8'h10
`define DCC_OFF_STAT 8'h2C
`define DCC_RST_WORD 32'h0000_0000
`define DCC_RST_VAL 12'h000
`define DCC_CTRL_MASK 32'h0000_0FFF
`define DCC_F_EN 0
`define DCC_F_BOFF 1
`define DCC_F_TEN 2
`define DCC_F_TSEL_LO 3
`define DCC_F_TSEL_HI 5
`define DCC_F_MODE_LO 6
`define DCC_F_MODE_HI 7
`define DCC_F_WID_LO 8
`define DCC_F_WID_HI 11
`define DCC_SWT0 0
`define DCC_SWT1 1
`define DCC_R12_HI 11
`define DCC_R12_LO 0
`define DCC_L12_HI 15
`define DCC_L12_LO 4
`define DCC_R8_HI 7
`define DCC_R8_LO 0
`define DCC_WID_MAX_CODE 4'hB
`define DCC_WID_MAX 4'hC
`define DCC_WID_ONE 4'h1
`define DCC_TSEL_EXT 3'h6
`define DCC_TSEL_SW 3'h7
`define DCC_LFSR_SEED 12'hAAA
`define DCC_LFSR_TAPS 12'h829
`endif

// ### src/dcc_pkg.sv
// Types shared by the converter front end
package dcc_pkg;
  typedef enum logic [1:0] {DCC_WAVE_NONE, DCC_WAVE_LFSR, DCC_WAVE_TRI} dcc_wave_e;
  typedef struct packed {
    logic [3:0] wave_width_ch0;
    logic [1:0] wave_shape_ch0;
    logic [2:0] trig_source_ch0;
    logic trig_on_ch0;
    logic buffer_off_ch0;
    logic channel_on_ch0;
  } dcc_ctrl_s;
  typedef struct packed {
    logic timer5;
    logic timer2;
    logic timer6;
    logic timer4;
    logic timer1;
    logic timer3;
    logic ext_line9;
  } dcc_trig_s;
  typedef struct packed {
    logic [11:0] data;
    logic channel_on;
    logic buffer_off;
  } dcc_core_s;
endpackage : dcc_pkg

// ### test/dcc_trig_model.sv
// Behavioural trigger sources facing the converter front end
`timescale 1ns/100ps
`default_nettype none

module dcc_trig_model (
  // Clock
  input wire logic clk,
  // Bench request
  input wire logic [2:0] code,
  input wire logic fire,
  // Trigger pulses
  output dcc_pkg::dcc_trig_s trig
);
  import dcc_pkg::*;
  initial trig = '0;
  // One-cycle pulse, codes 0..5 timers, 6 line 9; idle lines stay low
  always @(posedge clk) begin
    trig <= '0;
    if (fire && code != 3'h7) begin
      trig[3'h6 - code] <= 1'b1;
    end
  end
endmodule : dcc_trig_model
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the converter front end
`include "dcc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import dcc_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [`DCC_ADDR_W-1:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  dcc_trig_s TRIG_IN;
  dcc_core_s CORE;
  logic SOFT_TRIG_CH1;
  logic [2:0] code = 3'h0;
  logic fire = 1'b0;
  logic [11:0] last = 12'h000;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  dcc_top dcc_top_i (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TRIG_IN(TRIG_IN), .CORE(CORE), .SOFT_TRIG_CH1(SOFT_TRIG_CH1));
  dcc_trig_model dcc_trig_model_i (.clk(CLK), .code(code), .fire(fire), .trig(TRIG_IN));

  // 50 MHz clock
  always #10 CLK = ~CLK;

  // Cut a hang short; the tests need well under this
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  // Read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd

  // Ask the trigger model for one pulse
  task automatic pulse(input logic [2:0] k);
    @(posedge CLK);
    code <= k;
    fire <= 1'b1;
    @(posedge CLK);
    fire <= 1'b0;
  endtask : pulse

  // Bounded wait for the converter word
  task automatic wait_data(input logic [11:0] exp);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      #1;
      if (CORE.data === exp) break;
    end
  endtask : wait_data

  // Reset values of trigger and data registers
  task automatic t_reset();
    logic [31:0] d;
    logic [7:0] offs [4] = '{`DCC_OFF_SWT, `DCC_OFF_R12, `DCC_OFF_L12, `DCC_OFF_R8};
    foreach (offs[i]) begin
      rd(offs[i], d);
      check(d, `DCC_RST_WORD, "reset value");
    end
    check(CORE.data, `DCC_RST_VAL, "reset word");
    $display("test reset done");
  endtask : t_reset

  // Three alignments feed one held value, untriggered path follows
  task automatic t_align();
    logic [31:0] d;
    logic [7:0] offs [3] = '{`DCC_OFF_R12, `DCC_OFF_L12, `DCC_OFF_R8};
    logic [31:0] wd [3] = '{32'h0000_0ABC, 32'h0000_5670, 32'h0000_00C3};
    logic [11:0] ex [3] = '{12'hABC, 12'h567, 12'hC30};
    foreach (offs[i]) begin
      wr(offs[i], wd[i]);
      @(posedge CLK);
      #1 check(CORE.data, ex[i], "aligned load");
      rd(`DCC_OFF_R12, d);
      check(d, {20'h0, ex[i]}, "shared value");
      last = ex[i];
    end
    rd(`DCC_OFF_L12, d);
    check(d, {16'h0, last, 4'h0}, "left view");
    rd(`DCC_OFF_R8, d);
    check(d, {24'h0, last[11:4]}, "right8 view");
    rd(`DCC_OFF_STAT, d);
    check(d, {20'h0, last}, "status word");
    $display("test align done");
  endtask : t_align

  // Channel enable and buffer off bits
  task automatic t_ctrl();
    wr(`DCC_OFF_CTRL, 32'h3);
    repeat (2) @(posedge CLK);
    #1 check({CORE.channel_on, CORE.buffer_off}, 2'b11, "ctrl on");
    wr(`DCC_OFF_CTRL, 32'h1);
    repeat (2) @(posedge CLK);
    #1 check({CORE.channel_on, CORE.buffer_off}, 2'b10, "ctrl off");
    $display("test ctrl done");
  endtask : t_ctrl

  // Each source code gates the held value; other sources do not
  task automatic t_trig();
    logic [11:0] v;
    logic [31:0] d;
    for (int c = 0; c < 7; c++) begin
      v = 12'h100 + 12'(c);
      wr(`DCC_OFF_CTRL, 32'h5 | (32'(c) << 3));
      wr(`DCC_OFF_R12, {20'h0, v});
      pulse(3'((c + 1) % 7));
      repeat (3) @(posedge CLK);
      #1 check(CORE.data, last, "held back");
      pulse(3'(c));
      wait_data(v);
      check(CORE.data, v, "triggered");
      last = v;
    end
    wr(`DCC_OFF_CTRL, 32'h3D);
    wr(`DCC_OFF_R12, 32'h0000_07A5);
    repeat (3) @(posedge CLK);
    #1 check(CORE.data, last, "soft held");
    wr(`DCC_OFF_SWT, 32'h1);
    wait_data(12'h7A5);
    check(CORE.data, 12'h7A5, "soft trigger");
    rd(`DCC_OFF_SWT, d);
    check(d, 32'h0, "self clear");
    rd(`DCC_OFF_CTRL, d);
    check(d, 32'h3D, "control readback");
    $display("test trig done");
  endtask : t_trig

  // Source ignored with trigger enable clear; channel 1 soft pulse
  task automatic t_untrig();
    int n;
    n = 0;
    wr(`DCC_OFF_CTRL, 32'h11);
    wr(`DCC_OFF_R12, 32'h0000_0321);
    @(posedge CLK);
    #1 check(CORE.data, 12'h321, "untriggered");
    wr(`DCC_OFF_SWT, 32'h2);
    repeat (4) begin
      #1 if (SOFT_TRIG_CH1 === 1'b1) n++;
      @(posedge CLK);
    end
    check(32'(n), 32'h1, "ch1 pulse");
    $display("test untrig done");
  endtask : t_untrig

  // Triangle and noise ride on the held value within the wave width
  task automatic t_wave();
    logic [11:0] ex [5] = '{12'h200, 12'h201, 12'h202, 12'h203, 12'h202};
    wr(`DCC_OFF_R12, 32'h0000_0200);
    wr(`DCC_OFF_CTRL, 32'h1BD);
    foreach (ex[i]) begin
      wr(`DCC_OFF_SWT, 32'h1);
      wait_data(ex[i]);
      check(CORE.data, ex[i], "triangle step");
    end
    wr(`DCC_OFF_CTRL, 32'h07D);
    repeat (3) begin
      wr(`DCC_OFF_SWT, 32'h1);
      repeat (2) @(posedge CLK);
      #1 check(CORE.data[11:1], 11'h100, "noise within width");
    end
    $display("test wave done");
  endtask : t_wave

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    t_reset();
    t_align();
    t_ctrl();
    t_trig();
    t_untrig();
    t_wave();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
